/* hdl/rcs_pkg.sv */
// constants, register map and types of the run command source selector
// assumes one 100 MHz clock and a word-indexed register port
// Function
// - source 0: keypad run key starts acceleration if frequency is nonzero
// - source 0: keypad stop key makes the motor decelerate to stop
// - source 0: keypad direction setting picks forward or reverse
// - built-in keypad keys ignored while a remote keypad is connected
// - source 1: inputs one and two are separate forward and reverse run
// - source 2: input one is run, forward while input two is off
// - source 2: with run active, input two on selects reverse
// - source 3: run and stop come from the serial link settings
// - bipolar frequency source: polarity mapping applies in every run source
// - forward command: positive reference forward, negative stops then reverses
// - reverse command: positive reference reverse, negative reference forward
// - inhibit select: 0 both allowed, 1 blocks forward, 2 blocks reverse
// - autostart 1, source 1 or 2, terminal on at power-up: start
// - autorestart 1, source 1 or 2, terminal on as fault clears: start
package rcs_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int FN_W = 5;
   localparam int SYNC_N = 8;

   localparam logic [ADDR_W-1:0] REG_MODE = 4'h0;
   localparam logic [ADDR_W-1:0] REG_OPTION = 4'h1;
   localparam logic [ADDR_W-1:0] REG_LINK = 4'h2;
   localparam logic [ADDR_W-1:0] REG_SERIAL = 4'h3;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

   // field positions
   localparam int MODE_SRC_LO = 0;
   localparam int MODE_FRQ_LO = 4;
   localparam int OPT_KDIR = 0;
   localparam int OPT_INH_LO = 1;
   localparam int OPT_AUTO = 3;
   localparam int OPT_RESTART = 4;
   localparam int OPT_FN1_LO = 8;
   localparam int OPT_FN2_LO = 16;
   localparam int LNK_PROT = 0;
   localparam int LNK_STN_LO = 8;
   localparam int LNK_BAUD_LO = 16;
   localparam int SER_RUN = 0;
   localparam int SER_REV = 1;

   // codes
   localparam logic [1:0] SRC_KEYPAD = 2'h0;
   localparam logic [1:0] SRC_TERM_FR = 2'h1;
   localparam logic [1:0] SRC_TERM_RD = 2'h2;
   localparam logic [1:0] SRC_SERIAL = 2'h3;
   localparam logic [3:0] FRQ_BIPOLAR = 4'h2;
   localparam logic [1:0] INH_NONE = 2'h0;
   localparam logic [1:0] INH_FWD = 2'h1;
   localparam logic [1:0] INH_REV = 2'h2;
   localparam logic [FN_W-1:0] FN_FWD_RUN = 5'h00;
   localparam logic [FN_W-1:0] FN_REV_RUN = 5'h01;
   localparam logic [7:0] STN_MIN = 8'h01;
   localparam logic [7:0] STN_MAX = 8'hfa;
   localparam logic [2:0] BAUD_MAX = 3'h4;

   // reset values
   localparam logic [1:0] RST_SRC = SRC_TERM_FR;
   localparam logic [3:0] RST_FRQ = 4'h0;
   localparam logic RST_KDIR = 1'b0;
   localparam logic [7:0] RST_STN = 8'h01;
   localparam logic [2:0] RST_BAUD = 3'h3;

   // cycles for the pin synchronisers to hold settled values
   localparam logic [2:0] SETTLE_CYCLES = 3'h4;

   // synchroniser bit positions
   localparam int PIN_IN1 = 0;
   localparam int PIN_IN2 = 1;
   localparam int PIN_KRUN = 2;
   localparam int PIN_KSTOP = 3;
   localparam int PIN_RRUN = 4;
   localparam int PIN_RSTOP = 5;
   localparam int PIN_REMOTE = 6;
   localparam int PIN_NEG = 7;

   typedef enum logic [1:0] {RCS_ST_STOP, RCS_ST_RUN, RCS_ST_REV_WAIT} rcs_state_t;
endpackage

/* hdl/rcs_dir_if.sv */
// direction request passed from the source selector to the direction qualifier
// assumes both ends sit on clk_sys
`timescale 1ns/1ns
interface rcs_dir_if;
   logic base_run;
   logic base_rev;
   logic ref_negative;
   logic bipolar_en;
   logic [1:0] inhibit_sel;
   logic run_ok;
   logic want_rev;
   modport src (output base_run, base_rev, ref_negative, bipolar_en, inhibit_sel,
      input run_ok, want_rev);
   modport qual (input base_run, base_rev, ref_negative, bipolar_en, inhibit_sel,
      output run_ok, want_rev);
endinterface

/* hdl/rcs_pin_sync.sv */
// three-stage pin synchroniser, output follows once stages two and three agree
// assumes asynchronous pins and the system clock
`timescale 1ns/1ns
module rcs_pin_sync
   import rcs_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset, high
   input wire logic [SYNC_N-1:0] pin, // raw pins
   output logic [SYNC_N-1:0] q // settled levels
);
   logic [SYNC_N-1:0] s1, s2, s3;
   logic [SYNC_N-1:0] next_s1, next_s2, next_s3, next_q;

   genvar i;
   generate
      for (i = 0; i < SYNC_N; i++) begin : g_bit
         always_comb begin
            next_s1[i] = pin[i];
            next_s2[i] = s1[i];
            next_s3[i] = s2[i];
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q <= '0;
      end else begin
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
         q <= next_q;
      end
   end
endmodule

/* hdl/rcs_dir_qual.sv */
// applies reference polarity and per-direction inhibit to a run request
// combinational; the selector registers the result
`timescale 1ns/1ns
module rcs_dir_qual
   import rcs_pkg::*;
(
   rcs_dir_if.qual dq // request in, qualified request out
);
   logic rev;
   always_comb begin
      // with bipolar_en set, a negative reference swaps the commanded direction
      rev = dq.base_rev ^ (dq.bipolar_en & dq.ref_negative);
      dq.want_rev = rev;
      dq.run_ok = dq.base_run;
      if (dq.inhibit_sel == INH_FWD && !rev) begin
         dq.run_ok = 1'b0;
      end
      if (dq.inhibit_sel == INH_REV && rev) begin
         dq.run_ok = 1'b0;
      end
   end
endmodule

/* hdl/rcs_selector.sv */
// run command source selector: picks and qualifies run and direction
// assumes the ramp reports motor_stopped and protection reports fault_active
`timescale 1ns/1ns
module rcs_selector
   import rcs_pkg::*;
(
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic srst, // synchronous reset, high
   input wire logic [ADDR_W-1:0] addr, // register index
   input wire logic [DATA_W-1:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [DATA_W-1:0] rdata, // read data, cycle after rd
   input wire logic multifunction_input_one, // terminal one pin
   input wire logic multifunction_input_two, // terminal two pin
   input wire logic key_run, // built-in keypad run key
   input wire logic key_stop, // built-in keypad stop/reset key
   input wire logic remote_key_run, // remote keypad run key
   input wire logic remote_key_stop, // remote keypad stop/reset key
   input wire logic remote_present, // remote keypad connected
   input wire logic ref_negative, // bipolar_voltage_reference below zero
   input wire logic freq_nonzero, // operating frequency set nonzero
   input wire logic fault_active, // drive fault present
   input wire logic motor_stopped, // ramp at zero speed
   output logic run_cmd, // accelerate/run when high, decelerate when low
   output logic dir_reverse, // commanded direction, high reverse
   output logic link_protocol_select, // serial protocol select
   output logic [7:0] station_number, // serial station number
   output logic [2:0] baud_code // serial baud-rate code
);
   rcs_dir_if dq ();

   logic [SYNC_N-1:0] pins, lvl, lvl_d;
   logic [1:0] run_src, next_run_src;
   logic [3:0] frq_src, next_frq_src;
   logic keypad_direction_select, next_kdir;
   logic [1:0] direction_inhibit_select, next_inh;
   logic power_on_autostart, next_auto;
   logic fault_reset_autorestart, next_restart;
   logic [FN_W-1:0] input_one_function, next_fn1;
   logic [FN_W-1:0] input_two_function, next_fn2;
   logic next_prot;
   logic [7:0] next_stn;
   logic [2:0] next_baud;
   logic ser_run, next_ser_run, ser_rev, next_ser_rev;
   logic [DATA_W-1:0] next_rdata;
   logic kp_latch, next_kp_latch;
   logic restart_block, next_restart_block;
   logic powerup, next_powerup;
   logic fault_d, next_fault_d;
   logic [2:0] settle, next_settle;
   rcs_state_t state, next_state;
   logic next_run_cmd, next_dir_reverse;
   logic [SYNC_N-1:0] next_lvl_d;

   // comb helpers
   logic press_run, press_stop, forward_run_input, rx, term_mode, term_level, settled;
   logic fault_clear, eff_run, src_run, src_rev;

   assign pins = {ref_negative, remote_present, remote_key_stop, remote_key_run,
      key_stop, key_run, multifunction_input_two, multifunction_input_one};

   rcs_pin_sync u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin(pins),
      .q(lvl)
   );

   rcs_dir_qual u_qual (
      .dq(dq.qual)
   );

   // key presses from whichever keypad is active
   always_comb begin
      if (lvl[PIN_REMOTE]) begin
         press_run = lvl[PIN_RRUN] & ~lvl_d[PIN_RRUN];
         press_stop = lvl[PIN_RSTOP] & ~lvl_d[PIN_RSTOP];
      end else begin
         press_run = lvl[PIN_KRUN] & ~lvl_d[PIN_KRUN];
         press_stop = lvl[PIN_KSTOP] & ~lvl_d[PIN_KSTOP];
      end
   end

   // terminal decode and source selection
   always_comb begin
      forward_run_input = (input_one_function == FN_FWD_RUN && lvl[PIN_IN1])
         || (input_two_function == FN_FWD_RUN && lvl[PIN_IN2]);
      rx = (input_one_function == FN_REV_RUN && lvl[PIN_IN1])
         || (input_two_function == FN_REV_RUN && lvl[PIN_IN2]);
      term_mode = (run_src == SRC_TERM_FR) || (run_src == SRC_TERM_RD);
      src_run = 1'b0;
      src_rev = 1'b0;
      term_level = 1'b0;
      unique case (run_src)
         SRC_KEYPAD: begin
            src_run = kp_latch;
            src_rev = keypad_direction_select;
         end
         SRC_TERM_FR: begin
            // both terminals on counts as a stop request
            src_run = forward_run_input ^ rx;
            src_rev = rx;
            term_level = forward_run_input | rx;
         end
         SRC_TERM_RD: begin
            src_run = forward_run_input;
            src_rev = rx;
            term_level = forward_run_input;
         end
         SRC_SERIAL: begin
            src_run = ser_run;
            src_rev = ser_rev;
         end
      endcase
      dq.base_run = src_run;
      dq.base_rev = src_rev;
      dq.ref_negative = lvl[PIN_NEG];
      dq.bipolar_en = (frq_src == FRQ_BIPOLAR);
      dq.inhibit_sel = direction_inhibit_select;
   end

   // start gating after power-up and fault reset
   always_comb begin
      settled = (settle == SETTLE_CYCLES);
      fault_clear = fault_d & ~fault_active;
      next_fault_d = fault_active;
      next_settle = settled ? settle : settle + 3'h1;
      next_powerup = powerup & ~settled;
      next_restart_block = restart_block;
      // synchroniser outputs are meaningless until settled
      if (settled) begin
         if (!term_level) begin
            next_restart_block = 1'b0;
         end else if (powerup && power_on_autostart) begin
            next_restart_block = 1'b0;
         end
      end
      if (fault_clear && !fault_reset_autorestart) begin
         next_restart_block = 1'b1;
      end
      if (fault_clear && fault_reset_autorestart && term_level) begin
         next_restart_block = 1'b0;
      end
      eff_run = dq.run_ok && !fault_active && settled
         && !(term_mode && restart_block);
   end

   // keypad run latch
   always_comb begin
      next_kp_latch = kp_latch;
      if (press_stop || fault_active || run_src != SRC_KEYPAD) begin
         next_kp_latch = 1'b0;
      end else if (press_run && freq_nonzero) begin
         next_kp_latch = 1'b1;
      end
   end

   // run state; a direction change goes through a full stop
   always_comb begin
      next_state = state;
      next_dir_reverse = dir_reverse;
      unique case (state)
         RCS_ST_STOP: begin
            if (eff_run) begin
               next_state = RCS_ST_RUN;
               next_dir_reverse = dq.want_rev;
            end
         end
         RCS_ST_RUN: begin
            if (!eff_run) begin
               next_state = RCS_ST_STOP;
            end else if (dq.want_rev != dir_reverse) begin
               next_state = RCS_ST_REV_WAIT;
            end
         end
         RCS_ST_REV_WAIT: begin
            if (!eff_run) begin
               next_state = RCS_ST_STOP;
            end else if (motor_stopped) begin
               next_state = RCS_ST_RUN;
               next_dir_reverse = dq.want_rev;
            end
         end
         default: next_state = RCS_ST_STOP;
      endcase
      next_run_cmd = (next_state == RCS_ST_RUN);
      next_lvl_d = lvl;
   end

   // register port
   always_comb begin
      next_run_src = run_src;
      next_frq_src = frq_src;
      next_kdir = keypad_direction_select;
      next_inh = direction_inhibit_select;
      next_auto = power_on_autostart;
      next_restart = fault_reset_autorestart;
      next_fn1 = input_one_function;
      next_fn2 = input_two_function;
      next_prot = link_protocol_select;
      next_stn = station_number;
      next_baud = baud_code;
      next_ser_run = ser_run;
      next_ser_rev = ser_rev;
      next_rdata = '0;
      if (wr) begin
         unique case (addr)
            REG_MODE: begin
               next_run_src = wdata[MODE_SRC_LO +: 2];
               next_frq_src = wdata[MODE_FRQ_LO +: 4];
            end
            REG_OPTION: begin
               next_kdir = wdata[OPT_KDIR];
               // code 3 is not a valid inhibit choice
               if (wdata[OPT_INH_LO +: 2] != 2'h3) begin
                  next_inh = wdata[OPT_INH_LO +: 2];
               end
               next_auto = wdata[OPT_AUTO];
               next_restart = wdata[OPT_RESTART];
               next_fn1 = wdata[OPT_FN1_LO +: FN_W];
               next_fn2 = wdata[OPT_FN2_LO +: FN_W];
            end
            REG_LINK: begin
               next_prot = wdata[LNK_PROT];
               // out-of-range link settings are ignored
               if (wdata[LNK_STN_LO +: 8] >= STN_MIN && wdata[LNK_STN_LO +: 8] <= STN_MAX) begin
                  next_stn = wdata[LNK_STN_LO +: 8];
               end
               if (wdata[LNK_BAUD_LO +: 3] <= BAUD_MAX) begin
                  next_baud = wdata[LNK_BAUD_LO +: 3];
               end
            end
            REG_SERIAL: begin
               next_ser_run = wdata[SER_RUN];
               next_ser_rev = wdata[SER_REV];
            end
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            REG_MODE: begin
               next_rdata[MODE_SRC_LO +: 2] = run_src;
               next_rdata[MODE_FRQ_LO +: 4] = frq_src;
            end
            REG_OPTION: begin
               next_rdata[OPT_KDIR] = keypad_direction_select;
               next_rdata[OPT_INH_LO +: 2] = direction_inhibit_select;
               next_rdata[OPT_AUTO] = power_on_autostart;
               next_rdata[OPT_RESTART] = fault_reset_autorestart;
               next_rdata[OPT_FN1_LO +: FN_W] = input_one_function;
               next_rdata[OPT_FN2_LO +: FN_W] = input_two_function;
            end
            REG_LINK: begin
               next_rdata[LNK_PROT] = link_protocol_select;
               next_rdata[LNK_STN_LO +: 8] = station_number;
               next_rdata[LNK_BAUD_LO +: 3] = baud_code;
            end
            REG_SERIAL: begin
               next_rdata[SER_RUN] = ser_run;
               next_rdata[SER_REV] = ser_rev;
            end
            REG_STATUS: begin
               next_rdata[0] = run_cmd;
               next_rdata[1] = dir_reverse;
               next_rdata[3:2] = state;
               next_rdata[4] = restart_block;
               next_rdata[5] = kp_latch;
               next_rdata[6 +: SYNC_N] = lvl;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         run_src <= RST_SRC;
         frq_src <= RST_FRQ;
         keypad_direction_select <= RST_KDIR;
         direction_inhibit_select <= INH_NONE;
         power_on_autostart <= 1'b0;
         fault_reset_autorestart <= 1'b0;
         input_one_function <= FN_FWD_RUN;
         input_two_function <= FN_REV_RUN;
         link_protocol_select <= 1'b0;
         station_number <= RST_STN;
         baud_code <= RST_BAUD;
         ser_run <= 1'b0;
         ser_rev <= 1'b0;
         rdata <= '0;
         kp_latch <= 1'b0;
         restart_block <= 1'b1;
         powerup <= 1'b1;
         fault_d <= 1'b0;
         settle <= 3'h0;
         state <= RCS_ST_STOP;
         run_cmd <= 1'b0;
         dir_reverse <= 1'b0;
         lvl_d <= '0;
      end else begin
         run_src <= next_run_src;
         frq_src <= next_frq_src;
         keypad_direction_select <= next_kdir;
         direction_inhibit_select <= next_inh;
         power_on_autostart <= next_auto;
         fault_reset_autorestart <= next_restart;
         input_one_function <= next_fn1;
         input_two_function <= next_fn2;
         link_protocol_select <= next_prot;
         station_number <= next_stn;
         baud_code <= next_baud;
         ser_run <= next_ser_run;
         ser_rev <= next_ser_rev;
         rdata <= next_rdata;
         kp_latch <= next_kp_latch;
         restart_block <= next_restart_block;
         powerup <= next_powerup;
         fault_d <= next_fault_d;
         settle <= next_settle;
         state <= next_state;
         run_cmd <= next_run_cmd;
         dir_reverse <= next_dir_reverse;
         lvl_d <= next_lvl_d;
      end
   end
endmodule

/* test/rcs_selector_assertions.sv */
// port checks for the selector: reset values, read timing, run and direction
// assumes a bind to rcs_selector, one clock, synchronous reset
`timescale 1ns/1ns
module rcs_selector_checker
   import rcs_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   input wire logic [ADDR_W-1:0] addr, // register index
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [DATA_W-1:0] rdata, // read data
   input wire logic fault_active, // fault present
   input wire logic run_cmd, // run output
   input wire logic dir_reverse, // direction output
   input wire logic link_protocol_select, // protocol select
   input wire logic [7:0] station_number, // station number
   input wire logic [2:0] baud_code // baud code
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_reset_values:
      assert property ($fell(srst) |-> !run_cmd && !dir_reverse && !link_protocol_select
         && station_number == 8'h01 && baud_code == 3'h3) else $error("bad value after reset");
   a_no_early_run:
      assert property ($fell(srst) |-> !run_cmd [*4]) else $error("run too soon after reset");
   a_read_idle:
      assert property (!$past(rd) |-> rdata == '0) else $error("read data outside its cycle");
   a_station_range:
      assert property (station_number inside {[8'h01:8'hfa]}) else $error("station out of range");
   a_baud_range:
      assert property (baud_code <= 3'h4) else $error("baud code out of range");
   a_fault_stop:
      assert property (fault_active |=> !run_cmd) else $error("running during fault");
   a_rev_stopped:
      assert property ($changed(dir_reverse) |-> !$past(run_cmd))
         else $error("direction changed while running");
   a_link_write_only:
      assert property ($changed(station_number) || $changed(baud_code)
         || $changed(link_protocol_select) |-> $past(wr) && $past(addr) == REG_LINK)
         else $error("link setting changed without a write");

   cover property ($rose(run_cmd) && dir_reverse);
   cover property ($fell(run_cmd) && !fault_active);
   cover property (rd ##1 rdata != '0);
endmodule

bind rcs_selector rcs_selector_checker u_chk (.clk_sys(clk_sys), .srst(srst), .addr(addr),
   .wr(wr), .rd(rd), .rdata(rdata), .fault_active(fault_active), .run_cmd(run_cmd),
   .dir_reverse(dir_reverse), .link_protocol_select(link_protocol_select),
   .station_number(station_number), .baud_code(baud_code));

/* test/rcs_panel_model.sv */
// panel model: run terminals, built-in and remote keypads, reference sign
// assumes calls from the bench's main process; pins move after a rising edge
`timescale 1ns/1ns
module rcs_panel_model (
   input wire logic clk_sys, // system clock
   output logic in1, // terminal one level
   output logic in2, // terminal two level
   output logic remote, // remote keypad connected
   output logic neg, // reference below zero
   output logic [3:0] keys // run, stop, remote run, remote stop
);
   initial begin
      {neg, remote, in2, in1} = 4'h0;
      keys = 4'h0;
   end
   task put_pins(input logic [3:0] v);
      @(posedge clk_sys);
      {neg, remote, in2, in1} <= v;
   endtask
   // held well past the pin sync so a press is never lost
   task press(input int k);
      @(posedge clk_sys);
      keys[k] <= 1'b1;
      repeat (6) @(posedge clk_sys);
      keys[k] <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule

/* test/run_command_source_selector_tb_top.sv */
// self-checking bench for the run command source selector
// assumes rcs_pkg and the panel model; inputs move by NBA at rising edges
`timescale 1ns/1ns
module run_command_source_selector_tb_top import rcs_pkg::*;;
   typedef struct packed {
      logic [1:0] src;
      logic bip;
      logic [1:0] inh;
      logic [1:0] ser;
      logic [3:0] pin;
      logic run;
      logic rev;
   } rcs_row_t;
   logic clk_sys;
   logic srst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic freq_nonzero;
   logic fault_active;
   logic motor_stopped;
   logic [DATA_W-1:0] rdata;
   logic run_cmd, dir_reverse, link_protocol_select, in1, in2, remote, neg;
   logic [7:0] station_number;
   logic [2:0] baud_code;
   logic [3:0] keys;
   int errors = 0;
   int n_checks = 0;
   // src, bipolar, inhibit, serial, {neg,remote,in2,in1}, run, reverse
   rcs_row_t rows [15] = '{
      '{2'h1, 1'b0, 2'h0, 2'h3, 4'h1, 1'b1, 1'b0},
      '{2'h1, 1'b0, 2'h0, 2'h0, 4'h2, 1'b1, 1'b1},
      '{2'h1, 1'b0, 2'h0, 2'h0, 4'h3, 1'b0, 1'b0},
      '{2'h2, 1'b0, 2'h0, 2'h0, 4'h1, 1'b1, 1'b0},
      '{2'h2, 1'b0, 2'h0, 2'h0, 4'h3, 1'b1, 1'b1},
      '{2'h2, 1'b0, 2'h0, 2'h0, 4'h2, 1'b0, 1'b0},
      '{2'h1, 1'b0, 2'h1, 2'h0, 4'h1, 1'b0, 1'b0},
      '{2'h1, 1'b0, 2'h1, 2'h0, 4'h2, 1'b1, 1'b1},
      '{2'h1, 1'b0, 2'h2, 2'h0, 4'h2, 1'b0, 1'b0},
      '{2'h3, 1'b0, 2'h0, 2'h3, 4'h0, 1'b1, 1'b1},
      '{2'h3, 1'b0, 2'h0, 2'h1, 4'h1, 1'b1, 1'b0},
      '{2'h0, 1'b0, 2'h0, 2'h0, 4'h1, 1'b0, 1'b0},
      '{2'h1, 1'b1, 2'h0, 2'h0, 4'h9, 1'b1, 1'b1},
      '{2'h1, 1'b1, 2'h0, 2'h0, 4'ha, 1'b1, 1'b0},
      '{2'h3, 1'b1, 2'h0, 2'h1, 4'h8, 1'b1, 1'b1}};

   rcs_panel_model panel (.clk_sys(clk_sys), .in1(in1), .in2(in2), .remote(remote),
      .neg(neg), .keys(keys));
   rcs_selector dut (.clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .multifunction_input_one(in1), .multifunction_input_two(in2),
      .key_run(keys[0]), .key_stop(keys[1]), .remote_key_run(keys[2]),
      .remote_key_stop(keys[3]), .remote_present(remote), .ref_negative(neg),
      .freq_nonzero(freq_nonzero), .fault_active(fault_active),
      .motor_stopped(motor_stopped), .run_cmd(run_cmd), .dir_reverse(dir_reverse),
      .link_protocol_select(link_protocol_select), .station_number(station_number),
      .baud_code(baud_code));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      chk(rdata, exp);
   endtask
   // direction only matters while running
   task automatic chk_out(input logic r, input logic v);
      @(negedge clk_sys);
      chk({30'h0, dir_reverse & run_cmd, run_cmd}, {30'h0, v & r, r});
   endtask
   task automatic chk_link(input logic [11:0] exp);
      @(negedge clk_sys);
      chk({20'h0, baud_code, station_number, link_protocol_select}, {20'h0, exp});
   endtask
   task automatic results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      results();
   end

   initial begin
      {srst, motor_stopped} <= 2'h3;
      {addr, wdata, wr, rd, freq_nonzero, fault_active} <= '0;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      foreach (rows[i]) begin
         panel.put_pins({rows[i].pin[3], 3'h0});
         wr_reg(REG_SERIAL, {30'h0, rows[i].ser});
         wr_reg(REG_OPTION, 32'h0001_0000 | {29'h0, rows[i].inh, 1'b0});
         wr_reg(REG_MODE, {24'h0, (rows[i].bip ? FRQ_BIPOLAR : 4'h0), 2'h0, rows[i].src});
         cyc(8);
         panel.put_pins(rows[i].pin);
         cyc(12);
         chk_out(rows[i].run, rows[i].rev);
      end
      panel.put_pins(4'h0);
      wr_reg(REG_MODE, 32'h0);
      panel.press(0);
      chk_out(1'b0, 1'b0);
      @(posedge clk_sys);
      freq_nonzero <= 1'b1;
      panel.press(0);
      chk_out(1'b1, 1'b0);
      panel.press(1);
      chk_out(1'b0, 1'b0);
      wr_reg(REG_OPTION, 32'h0001_0001);
      panel.press(0);
      chk_out(1'b1, 1'b1);
      panel.press(1);
      panel.put_pins(4'h4);
      panel.press(0);
      chk_out(1'b0, 1'b0);
      panel.press(2);
      chk_out(1'b1, 1'b1);
      panel.press(3);
      chk_out(1'b0, 1'b0);
      // reversal waits for the ramp to report zero speed
      panel.put_pins(4'h0);
      wr_reg(REG_MODE, 32'h2);
      wr_reg(REG_OPTION, 32'h0001_0000);
      panel.put_pins(4'h1);
      cyc(12);
      chk_out(1'b1, 1'b0);
      @(posedge clk_sys);
      motor_stopped <= 1'b0;
      panel.put_pins(4'h3);
      cyc(12);
      chk_out(1'b0, 1'b0);
      @(posedge clk_sys);
      motor_stopped <= 1'b1;
      cyc(3);
      chk_out(1'b1, 1'b1);
      panel.put_pins(4'h0);
      wr_reg(REG_MODE, 32'h1);
      panel.put_pins(4'h1);
      cyc(12);
      chk_out(1'b1, 1'b0);
      @(posedge clk_sys);
      fault_active <= 1'b1;
      cyc(2);
      chk_out(1'b0, 1'b0);
      @(posedge clk_sys);
      fault_active <= 1'b0;
      cyc(12);
      chk_out(1'b0, 1'b0);
      panel.put_pins(4'h0);
      cyc(8);
      panel.put_pins(4'h1);
      cyc(12);
      chk_out(1'b1, 1'b0);
      wr_reg(REG_OPTION, 32'h0001_0010);
      @(posedge clk_sys);
      fault_active <= 1'b1;
      cyc(3);
      fault_active <= 1'b0;
      cyc(12);
      chk_out(1'b1, 1'b0);
      wr_reg(REG_LINK, 32'h0004_fa01);
      chk_link({3'h4, 8'hfa, 1'b1});
      wr_reg(REG_LINK, 32'h0005_fb00);
      chk_link({3'h4, 8'hfa, 1'b0});
      wr_reg(REG_LINK, 32'h0002_0000);
      chk_link({3'h2, 8'hfa, 1'b0});
      rd_reg(4'hf, 32'h0);
      rd_reg(REG_MODE, 32'h1);
      // second reset with a terminal still on
      @(posedge clk_sys);
      srst <= 1'b1;
      cyc(5);
      srst <= 1'b0;
      cyc(20);
      chk_out(1'b0, 1'b0);
      rd_reg(REG_MODE, 32'h1);
      rd_reg(REG_OPTION, 32'h0001_0000);
      chk_link({3'h3, 8'h01, 1'b0});
      panel.put_pins(4'h0);
      cyc(8);
      panel.put_pins(4'h1);
      cyc(12);
      chk_out(1'b1, 1'b0);
      @(posedge clk_sys);
      srst <= 1'b1;
      cyc(5);
      srst <= 1'b0;
      wr_reg(REG_OPTION, 32'h0001_0008);
      cyc(20);
      chk_out(1'b1, 1'b0);
      results();
   end
endmodule
